//--- hdl/tsn_pkg.sv
// shared constants for the temperature sensor two-wire slave port
package tsn_pkg;
    localparam logic [3:0]  ADDR_CODE_STD  = 4'h3;   // upper address code, standard part
    localparam logic [3:0]  ADDR_CODE_ALT  = 4'h9;   // upper address code, factory variant
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [7:0]  IDLE_BYTE      = 8'hff;  // all ones keeps the data line released
    localparam logic [7:0]  PTR_RESET      = 8'h00;
    localparam int          CLK_KHZ        = 250000;
    localparam int          TOUT_MIN_MS    = 25;
    localparam int          TOUT_CYC       = TOUT_MIN_MS * CLK_KHZ;
    localparam int          TCNT_W         = 23;
    localparam int          IDX_W          = 4;
endpackage : tsn_pkg

//--- hdl/tsn_sync2.sv
// two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module tsn_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : tsn_sync2

//--- hdl/tsn_buf2.sv
// shift-style fifo, head entry is a flop so outputs come straight from registers
`timescale 1ns/1ps
module tsn_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    logic [DEPTH-1:0] vld_q, vld_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic             pop;
    logic             push;

    assign pop       = vld_q[0] & out_ready;
    assign push      = in_valid & ~vld_q[DEPTH-1];
    assign in_ready  = ~vld_q[DEPTH-1];
    assign out_valid = vld_q[0];
    assign out_data  = mem_q[0];

    always_comb begin
        logic [DEPTH-1:0] sv;
        sv = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (pop) begin
                sv[i]    = (i < DEPTH-1) ? vld_q[(i+1) % DEPTH] : 1'b0;
                mem_d[i] = (i < DEPTH-1) ? mem_q[(i+1) % DEPTH] : mem_q[i];
            end else begin
                sv[i]    = vld_q[i];
                mem_d[i] = mem_q[i];
            end
        end
        vld_d = sv;
        // new word lands in the first slot left free after the shift
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !sv[i] && (i == 0 || sv[(i+DEPTH-1) % DEPTH])) begin
                vld_d[i] = 1'b1;
                mem_d[i] = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vld_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            vld_q <= vld_d;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= mem_d[i];
            end
        end
    end
endmodule : tsn_buf2

//--- hdl/tsn_slave_port.sv
// two-wire slave front end of the temperature sensor: bus engine, crossing, pointer, timeout, alert
`timescale 1ns/1ps
module tsn_slave_port #(
    parameter bit ALT_ADDR = 1'b0,
    parameter int TOUT_CYC = tsn_pkg::TOUT_CYC,
    parameter int RX_DEPTH = 2
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       link_clk,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [2:0] addr_strap,
    input  wire logic       alert_trip,
    output logic            alert_o,
    output logic            alert_oe,
    output logic      [7:0] ptr,
    output logic      [tsn_pkg::IDX_W-1:0] rd_index,
    input  wire logic [7:0] rd_data,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    input  wire logic       rx_ready
);
    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_ADDR    = 8'h02,
        ST_ADDRACK = 8'h04,
        ST_RX      = 8'h08,
        ST_RXACK   = 8'h10,
        ST_TX      = 8'h20,
        ST_TXACK   = 8'h40,
        ST_SKIP    = 8'h80
    } tsn_state_e;

    localparam logic [3:0] ADDR_CODE = ALT_ADDR ? tsn_pkg::ADDR_CODE_ALT : tsn_pkg::ADDR_CODE_STD;

    // ---------------- link domain ----------------
    logic       l_scl, l_sda, l_tmo, l_rx_ack, l_rd_ack;
    logic [2:0] l_strap;
    logic       tmo_q, rx_ack_q, rd_ack_q;
    logic [7:0] rd_hold_q;

    tsn_sync2 #(.W(8)) u_link_sync (
        .clk   (link_clk),
        .rst_b (rst_b),
        .d     ({scl_i, sda_i, addr_strap, tmo_q, rx_ack_q, rd_ack_q}),
        .q     ({l_scl, l_sda, l_strap, l_tmo, l_rx_ack, l_rd_ack})
    );

    tsn_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic       rw_q, rw_d;
    logic       first_q, first_d;
    logic       oe_q, oe_d;
    logic       ackd_q, ackd_d;
    logic       scl_p_q, sda_p_q;
    logic       rx_req_q, rx_req_d;
    logic [7:0] rx_byte_q, rx_byte_d;
    logic       rx_first_q, rx_first_d;
    logic       rd_req_q, rd_req_d;
    logic       rd_first_q, rd_first_d;
    logic       scl_rise, scl_fall, start_ev, stop_ev;
    logic [7:0] tx_byte;

    assign scl_rise = l_scl & ~scl_p_q;
    assign scl_fall = ~l_scl & scl_p_q;
    assign start_ev = l_scl & scl_p_q & sda_p_q & ~l_sda;
    assign stop_ev  = l_scl & scl_p_q & ~sda_p_q & l_sda;
    // read word is only trusted once its handshake has closed
    assign tx_byte  = (l_rd_ack == rd_req_q) ? rd_hold_q : tsn_pkg::IDLE_BYTE;

    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        sh_d       = sh_q;
        rw_d       = rw_q;
        first_d    = first_q;
        oe_d       = oe_q;
        ackd_d     = ackd_q;
        rx_req_d   = rx_req_q;
        rx_byte_d  = rx_byte_q;
        rx_first_d = rx_first_q;
        rd_req_d   = rd_req_q;
        rd_first_d = rd_first_q;
        if (l_tmo) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else if (start_ev) begin
            st_d  = ST_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else if (stop_ev) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], l_sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == tsn_pkg::BYTE_BITS) begin
                        if (st_q == ST_ADDR) begin
                            if (sh_q[7:4] == ADDR_CODE && sh_q[3:1] == l_strap) begin
                                st_d    = ST_ADDRACK;
                                oe_d    = 1'b1;
                                rw_d    = sh_q[0];
                                first_d = 1'b1;
                                if (sh_q[0]) begin
                                    rd_req_d   = ~rd_req_q; // prefetch during the ack clock
                                    rd_first_d = 1'b1;
                                end
                            end else begin
                                st_d = ST_SKIP;
                            end
                        end else begin
                            st_d = ST_RXACK;
                            // a full crossing means the word would be lost, so refuse it
                            if (rx_req_q == l_rx_ack) begin
                                oe_d       = 1'b1;
                                rx_req_d   = ~rx_req_q;
                                rx_byte_d  = sh_q;
                                rx_first_d = first_q;
                            end
                        end
                    end
                end
                ST_ADDRACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            st_d = ST_TX;
                            sh_d = tx_byte;
                            oe_d = ~tx_byte[7];
                        end else begin
                            st_d = ST_RX;
                            oe_d = 1'b0;
                        end
                    end
                end
                ST_RXACK: begin
                    if (scl_fall) begin
                        st_d    = ST_RX;
                        oe_d    = 1'b0;
                        cnt_d   = 4'h0;
                        first_d = 1'b0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == tsn_pkg::BYTE_BITS - 4'h1) begin
                            st_d = ST_TXACK;
                            oe_d = 1'b0;
                        end else begin
                            sh_d  = {sh_q[6:0], 1'b1};
                            oe_d  = ~sh_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        ackd_d = ~l_sda;
                        if (!l_sda) begin
                            rd_req_d   = ~rd_req_q;
                            rd_first_d = 1'b0;
                        end
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (ackd_q) begin
                            st_d = ST_TX;
                            sh_d = tx_byte;
                            oe_d = ~tx_byte[7];
                        end else begin
                            st_d = ST_SKIP;
                            oe_d = 1'b0;
                        end
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    oe_d = 1'b0;
                end
                default: begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= ST_IDLE;
            cnt_q      <= 4'h0;
            sh_q       <= 8'h00;
            rw_q       <= 1'b0;
            first_q    <= 1'b0;
            oe_q       <= 1'b0;
            ackd_q     <= 1'b0;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            rx_req_q   <= 1'b0;
            rx_byte_q  <= 8'h00;
            rx_first_q <= 1'b0;
            rd_req_q   <= 1'b0;
            rd_first_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            sh_q       <= sh_d;
            rw_q       <= rw_d;
            first_q    <= first_d;
            oe_q       <= oe_d;
            ackd_q     <= ackd_d;
            scl_p_q    <= l_scl;
            sda_p_q    <= l_sda;
            rx_req_q   <= rx_req_d;
            rx_byte_q  <= rx_byte_d;
            rx_first_q <= rx_first_d;
            rd_req_q   <= rd_req_d;
            rd_first_q <= rd_first_d;
        end
    end

    // of the two bus lines only the data line is ever driven, and only low; the clock pin is input only
    assign sda_oe = oe_q;
    assign sda_o  = 1'b0;

    // ---------------- system clock domain ----------------
    logic c_scl, c_rx_req, c_rd_req;

    tsn_sync2 #(.W(3)) u_sys_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({scl_i, rx_req_q, rd_req_q}),
        .q     ({c_scl, c_rx_req, c_rd_req})
    );

    logic [7:0]                ptr_q, ptr_d;
    logic [tsn_pkg::IDX_W-1:0] idx_q, idx_d;
    logic [7:0]                rd_hold_d;
    logic                      rd_ph_q, rd_ph_d;
    logic                      rx_ack_d, rd_ack_d;
    logic                      c_scl_p_q;
    logic [tsn_pkg::TCNT_W-1:0] tcnt_q, tcnt_d;
    logic                      tmo_d;
    logic                      alert_oe_q;
    logic                      rx_pend, rd_pend;
    logic                      buf_in_valid, buf_in_ready;

    assign rx_pend      = c_rx_req != rx_ack_q;
    assign rd_pend      = c_rd_req != rd_ack_q;
    // the pointer byte of a write is consumed here, only later bytes go to the stream
    assign buf_in_valid = rx_pend & ~rx_first_q;

    always_comb begin
        ptr_d     = ptr_q;
        idx_d     = idx_q;
        rd_hold_d = rd_hold_q;
        rd_ph_d   = rd_ph_q;
        rx_ack_d  = rx_ack_q;
        rd_ack_d  = rd_ack_q;
        tcnt_d    = tcnt_q;
        tmo_d     = tmo_q;
        if (rx_pend) begin
            if (rx_first_q) begin
                ptr_d    = rx_byte_q;
                rx_ack_d = ~rx_ack_q;
            end else if (buf_in_ready) begin
                rx_ack_d = ~rx_ack_q;
            end
        end
        // two steps so rd_data has a cycle to follow the new index
        if (rd_pend && !rd_ph_q) begin
            idx_d   = rd_first_q ? '0 : idx_q + 1'b1;
            rd_ph_d = 1'b1;
        end else if (rd_ph_q) begin
            rd_hold_d = rd_data;
            rd_ack_d  = ~rd_ack_q;
            rd_ph_d   = 1'b0;
        end
        if (c_scl != c_scl_p_q) begin
            tcnt_d = '0;
            tmo_d  = 1'b0;
        end else if (tcnt_q == tsn_pkg::TCNT_W'(TOUT_CYC)) begin
            tmo_d = 1'b1;
        end else begin
            tcnt_d = tcnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q      <= tsn_pkg::PTR_RESET;
            idx_q      <= '0;
            rd_hold_q  <= tsn_pkg::IDLE_BYTE;
            rd_ph_q    <= 1'b0;
            rx_ack_q   <= 1'b0;
            rd_ack_q   <= 1'b0;
            c_scl_p_q  <= 1'b1;
            tcnt_q     <= '0;
            tmo_q      <= 1'b0;
            alert_oe_q <= 1'b0;
        end else begin
            ptr_q      <= ptr_d;
            idx_q      <= idx_d;
            rd_hold_q  <= rd_hold_d;
            rd_ph_q    <= rd_ph_d;
            rx_ack_q   <= rx_ack_d;
            rd_ack_q   <= rd_ack_d;
            c_scl_p_q  <= c_scl;
            tcnt_q     <= tcnt_d;
            tmo_q      <= tmo_d;
            alert_oe_q <= alert_trip;
        end
    end

    tsn_buf2 #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_buf (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (buf_in_valid),
        .in_data   (rx_byte_q),
        .in_ready  (buf_in_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready)
    );

    assign ptr      = ptr_q;
    assign rd_index = idx_q;
    assign alert_oe = alert_oe_q;  // open drain: enable means pull low
    assign alert_o  = 1'b0;
endmodule : tsn_slave_port

//--- tb/tsn_slave_port_checker.sv
// concurrent checks at the ports of the two-wire slave port
`timescale 1ns/1ps
module tsn_slave_port_checker #(
    parameter bit ALT_ADDR = 1'b0,
    parameter int TOUT_CYC = 200
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       link_clk,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic [2:0] addr_strap,
    input wire logic       alert_trip,
    input wire logic       alert_o,
    input wire logic       alert_oe,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       rx_ready
);
    localparam logic [3:0] CODE = ALT_ADDR ? tsn_pkg::ADDR_CODE_ALT : tsn_pkg::ADDR_CODE_STD;
    logic       scl_d, sda_d, first_q, rd_q, scl_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    int         still_q;
    wire        rise = scl_i & ~scl_d;
    wire        strt = scl_i & scl_d & sda_d & ~sda_i;
    wire        stp  = scl_i & scl_d & ~sda_d & sda_i;
    wire        hit  = sh_q[7:1] == {CODE, addr_strap};

    // bit position counted on raw lines, independent of the design's synchroniser
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d   <= 1'b1;
            sda_d   <= 1'b1;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            first_q <= 1'b0;
            rd_q    <= 1'b0;
        end else begin
            scl_d <= scl_i;
            sda_d <= sda_i;
            if (strt || stp) begin
                cnt_q   <= 4'h0;
                first_q <= strt;
                rd_q    <= 1'b0;
            end else if (rise) begin
                cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
                sh_q  <= {sh_q[6:0], sda_i};
                if (cnt_q == 4'h8) begin
                    first_q <= 1'b0;
                    if (first_q) rd_q <= hit & sh_q[0];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q   <= 1'b1;
            still_q <= 0;
        end else begin
            scl_q   <= scl_i;
            still_q <= (scl_i != scl_q) ? 0 : still_q + 1;
        end
    end

    sequence s_cond;
        strt || stp;
    endsequence
    sequence s_quiet;
        !sda_oe [*8];
    endsequence

    a_alert_follow: assert property (@(posedge clk) disable iff (!rst_b)
        alert_trip |=> alert_oe) else $error("alert not driven");
    a_alert_clear: assert property (@(posedge clk) disable iff (!rst_b)
        !alert_trip |=> !alert_oe) else $error("alert not released");
    a_open_drain: assert property (@(posedge clk) disable iff (!rst_b)
        sda_o == 1'b0 && alert_o == 1'b0) else $error("open drain level wrong");
    a_cond_release: assert property (@(posedge link_clk) disable iff (!rst_b)
        s_cond |-> ##[1:4] !sda_oe) else $error("data held after start or stop");
    a_oe_rise_low: assert property (@(posedge link_clk) disable iff (!rst_b)
        $rose(sda_oe) |-> !$past(scl_i)) else $error("data driven while clock high");
    a_addr_ack: assert property (@(posedge link_clk) disable iff (!rst_b)
        first_q && rise && cnt_q == 4'h8 && hit |-> sda_oe) else $error("own address not acked");
    a_addr_ignore: assert property (@(posedge link_clk) disable iff (!rst_b)
        first_q && rise && cnt_q == 4'h8 && !hit |-> !sda_oe) else $error("foreign address acked");
    a_write_quiet: assert property (@(posedge link_clk) disable iff (!rst_b)
        !rd_q && rise && cnt_q < 4'h8 |-> !sda_oe) else $error("data driven in write");
    a_nak_release: assert property (@(posedge link_clk) disable iff (!rst_b)
        rd_q && !first_q && rise && cnt_q == 4'h8 && sda_i |-> ##1 s_quiet) else $error("driven after nak");
    a_tout_release: assert property (@(posedge clk) disable iff (!rst_b)
        still_q > TOUT_CYC + 200 |-> !sda_oe) else $error("no release on timeout");
    a_rx_hold: assert property (@(posedge clk) disable iff (!rst_b)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("stalled word lost");
endmodule : tsn_slave_port_checker

bind tsn_slave_port tsn_slave_port_checker #(.ALT_ADDR(ALT_ADDR), .TOUT_CYC(TOUT_CYC)) u_chk (
    .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(addr_strap), .alert_trip(alert_trip),
    .alert_o(alert_o), .alert_oe(alert_oe), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready)
);

//--- tb/tsn_master.sv
// two-wire bus master model: makes the clock, pulls data open drain
`timescale 1ns/1ps
module tsn_master #(
    parameter int H = 640
) (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    initial begin
        scl      = 1'b1; // idle with both lines high
        sda_pull = 1'b0;
    end

    task automatic start;
        #(H/4) sda_pull = 1'b0;
        #(H) scl = 1'b1;
        #(H) sda_pull = 1'b1; // data falls while clock high
        #(H) scl = 1'b0;
    endtask : start

    task automatic stop;
        #(H/4) sda_pull = 1'b1;
        #(H) scl = 1'b1;
        #(H) sda_pull = 1'b0; // data rises while clock high
        #(H);
    endtask : stop

    // n bits of {byte, ack bit} msb first; ack bit 1 leaves the line released
    task automatic xfer(input logic [7:0] w, input logic a, input int n, output logic [7:0] r, output logic ak);
        logic [8:0] v;
        logic [8:0] s;
        v = {w, a};
        s = '1;
        for (int i = 8; i > 8 - n; i--) begin
            #(H/4) sda_pull = ~v[i]; // change only while clock low
            #(H - H/4) scl = 1'b1;   // bit clock made here; start and stop move it too
            #(H/4) s[i] = sda;
            #(H - H/4) scl = 1'b0;
        end
        r  = s[8:1];
        ak = ~s[0];
    endtask : xfer
endmodule : tsn_master

//--- tb/tb_top.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module tb_top;
    typedef struct packed { logic [2:0] strap; logic [6:0] addr; logic ack; } tsn_row_s;
    localparam int       TOUT     = 2000;
    localparam tsn_row_s ROWS [5] = '{'{3'h5, 7'h1d, 1'b1}, '{3'h5, 7'h1c, 1'b0}, '{3'h5, 7'h15, 1'b0},
                                      '{3'h2, 7'h1a, 1'b1}, '{3'h2, 7'h4a, 1'b1}};
    localparam logic [7:0] WD [4] = '{8'ha5, 8'h3c, 8'h0f, 8'hc3};
    logic       clk        = 1'b0;
    logic       link_clk   = 1'b0;
    logic       rst_b      = 1'b0;
    logic       alert_trip = 1'b0;
    logic       rx_ready   = 1'b0;
    logic [2:0] addr_strap = 3'h5;
    logic [7:0] rd_data    = 8'h00;
    logic       scl, pull, sda_o, sda_oe, alert_o, alert_oe, rx_valid, ak, nk, alt_oe;
    logic [7:0] ptr, rx_data, r;
    logic [tsn_pkg::IDX_W-1:0] rd_index;
    logic [7:0] exp_q [$];
    int         error_cnt  = 0;
    int         n_tests    = 0;
    wire        sda        = ~((sda_oe & ~sda_o) | alt_oe | pull);

    always #2 clk = ~clk;
    initial begin
        #1.3;
        forever #80 link_clk = ~link_clk;
    end

    tsn_slave_port #(.TOUT_CYC(TOUT)) dut (
        .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_strap(addr_strap), .alert_trip(alert_trip), .alert_o(alert_o),
        .alert_oe(alert_oe), .ptr(ptr), .rd_index(rd_index), .rd_data(rd_data), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready)
    );
    // factory variant on the same bus: only the upper-code-1001 row is answered by it
    tsn_slave_port #(.ALT_ADDR(1'b1), .TOUT_CYC(TOUT)) dut_alt (
        .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(alt_oe), .addr_strap(addr_strap), .alert_trip(alert_trip), .alert_o(),
        .alert_oe(), .ptr(), .rd_index(), .rd_data(rd_data), .rx_valid(), .rx_data(),
        .rx_ready(rx_ready)
    );
    tsn_master m (.scl(scl), .sda_pull(pull), .sda(sda));

    // register source: byte depends on pointer and index so stale data shows
    // updated mid-cycle so it is valid one clock after the index moves
    always @(negedge clk) rd_data <= {ptr[3:0], rd_index};

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude;
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    always @(negedge clk) begin
        if (rx_valid === 1'b1 && rx_ready) begin
            if (exp_q.size() == 0) chk("rx_extra", 1, 0);
            else chk("rx_data", rx_data, exp_q.pop_front());
        end
    end

    initial begin
        #350000;
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge link_clk);
        chk("rst_sda_oe", sda_oe, 0);
        chk("rst_alert", alert_oe, 0);
        chk("rst_rx_valid", rx_valid, 0);
        chk("rst_ptr", ptr, tsn_pkg::PTR_RESET);
        chk("rst_index", 8'(rd_index), 0);
        @(posedge clk) #1 rst_b = 1'b1;
        repeat (3) @(posedge link_clk);
        @(posedge clk) #1 alert_trip = 1'b1;
        @(posedge clk) #1 chk("alert_on", alert_oe, 1);
        alert_trip = 1'b0;
        @(posedge clk) #1 chk("alert_off", alert_oe, 0);
        foreach (ROWS[i]) begin
            @(posedge clk) #1 addr_strap = ROWS[i].strap;
            #700;
            m.start();
            m.xfer({ROWS[i].addr, 1'b0}, 1'b1, 9, r, ak);
            m.stop();
            chk("addr_ack", ak, ROWS[i].ack);
        end
        // stalled consumer: acked words must all arrive later, in order
        @(posedge clk) #1 addr_strap = 3'h5;
        #700;
        nk = 1'b0;
        m.start();
        m.xfer(8'h3a, 1'b1, 9, r, ak);
        chk("wr_ack", ak, 1);
        m.xfer(8'h05, 1'b1, 9, r, ak);
        chk("ptr_ack", ak, 1);
        foreach (WD[i]) begin
            m.xfer(WD[i], 1'b1, 9, r, ak);
            if (ak) exp_q.push_back(WD[i]);
            if (i < 2) chk("data_ack", ak, 1);
            else if (!ak) nk = 1'b1;
        end
        m.stop();
        chk("full_nak", nk, 1);
        chk("ptr", ptr, 8'h05);
        @(posedge clk) #1 rx_ready = 1'b1;
        repeat (20) @(posedge clk);
        chk("drained", 8'(exp_q.size()), 0);
        // second read reuses the pointer without rewriting it
        for (int k = 0; k < 2; k++) begin
            m.start();
            m.xfer(8'h3b, 1'b1, 9, r, ak);
            chk("rd_ack", ak, 1);
            for (int j = 0; j < 2 - k; j++) begin
                m.xfer(8'hff, (j == 1 - k), 9, r, ak);
                chk("rd_byte", r, 8'h50 + 8'(j));
            end
            m.stop();
        end
        m.start();
        m.xfer(8'h3a, 1'b1, 9, r, ak);
        m.xfer(8'h0a, 1'b1, 4, r, ak);
        m.stop();
        chk("ptr_kept", ptr, 8'h05);
        chk("abort_rel", sda_oe, 0);
        // clock parked low while the device drives a zero bit
        m.start();
        m.xfer(8'h3b, 1'b1, 9, r, ak);
        #1000 chk("tx_bit", sda_oe, 1);
        #(TOUT * 4 + 2000) chk("tout_rel", sda_oe, 0);
        m.start();
        m.stop();
        conclude();
    end
endmodule : tb_top
